// *** rtl/ptc_pkg.sv ***
package ptc_pkg;
    localparam logic [1:0] PTC_LVL_ZERO = 2'h0;
    localparam logic [1:0] PTC_LVL_POS = 2'h1;
    localparam logic [1:0] PTC_LVL_NEG = 2'h3;
    localparam int PTC_SIX_ZERO_RUN = 6;
    localparam int PTC_TZS_ZERO_RUN = 4;
    localparam logic [2:0] PTC_RUN_RESET = 3'h0;
    localparam logic PTC_POL_RESET = 1'b1;
    typedef enum logic [2:0] {
        PTC_MODE_POLAR_C = 3'h0,
        PTC_MODE_AMI_C = 3'h1,
        PTC_MODE_TZS_C = 3'h2,
        PTC_MODE_DIF_C = 3'h3,
        PTC_MODE_DIH_C = 3'h4,
        PTC_MODE_PAIR_C = 3'h5,
        PTC_MODE_DUO_C = 3'h6
    } ptc_mode_type;
    typedef struct packed {
        logic bit_valid;
        logic data;
        logic violation;
    } ptc_rx_type;
endpackage

// *** rtl/ptc_codec.sv ***
module ptc_codec
    import ptc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire ptc_pkg::ptc_mode_type mode_i,
    input wire logic six_zero_en_i,
    input wire logic tx_data_i,
    output logic tx_take_o,
    output logic [1:0] line_o,
    input wire logic [1:0] line_i,
    input wire logic rx_bit_clk_i,
    output ptc_pkg::ptc_rx_type rx_o
);
    import ptc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // half-bit phase: phase 0 is first half, bit taken at phase 0
    logic phase_q, phase_d;
    logic [1:0] line_q, line_d;
    logic pol_q, pol_d;
    logic prev_q, prev_d;
    logic pre_q, pre_d;
    logic pair_mode_q, pair_mode_d;
    logic pair_half_q, pair_half_d;
    logic pair_first_q, pair_first_d;
    logic [2:0] run_q, run_d;
    logic [2:0] sub_q, sub_d;
    logic take_q, take_d;
    logic cur_q, cur_d;

    function automatic logic [1:0] lvl(input logic p);
        lvl = p ? PTC_LVL_POS : PTC_LVL_NEG;
    endfunction

    always_comb begin
        phase_d = ~phase_q;
        line_d = line_q;
        pol_d = pol_q;
        prev_d = prev_q;
        pre_d = pre_q;
        pair_mode_d = pair_mode_q;
        pair_half_d = pair_half_q;
        pair_first_d = pair_first_q;
        run_d = run_q;
        sub_d = sub_q;
        take_d = ~phase_q;
        cur_d = cur_q;
        if (!phase_q) begin
            cur_d = tx_data_i;
            case (mode_i)
                PTC_MODE_POLAR_C: line_d = lvl(tx_data_i);
                PTC_MODE_AMI_C: begin
                    if (tx_data_i) begin
                        line_d = lvl(pol_q);
                        pol_d = ~pol_q;
                        run_d = PTC_RUN_RESET;
                        sub_d = 3'h0;
                    end else if (six_zero_en_i &&
                                 run_q == 3'(PTC_SIX_ZERO_RUN - 1)) begin
                        // substitution: violation at end of run keeps pulses present
                        line_d = lvl(~pol_q);
                        run_d = PTC_RUN_RESET;
                    end else begin
                        line_d = PTC_LVL_ZERO;
                        run_d = run_q + 3'h1;
                    end
                end
                PTC_MODE_TZS_C: begin
                    if (tx_data_i) begin
                        line_d = lvl(pol_q);
                        pol_d = ~pol_q;
                        run_d = PTC_RUN_RESET;
                    end else if (run_q == 3'(PTC_TZS_ZERO_RUN - 1)) begin
                        line_d = lvl(~pol_q);
                        run_d = PTC_RUN_RESET;
                    end else begin
                        line_d = PTC_LVL_ZERO;
                        run_d = run_q + 3'h1;
                    end
                end
                PTC_MODE_DIF_C, PTC_MODE_DIH_C: begin
                    if (tx_data_i != prev_q) begin
                        line_d = lvl(pol_q);
                        pol_d = ~pol_q;
                    end else begin
                        line_d = PTC_LVL_ZERO;
                    end
                    prev_d = tx_data_i;
                end
                PTC_MODE_PAIR_C: begin
                    // pair table: first bit held, both bits select symbol pair
                    pair_half_d = ~pair_half_q;
                    if (!pair_half_q) begin
                        pair_first_d = tx_data_i;
                        line_d = PTC_LVL_ZERO;
                    end else begin
                        case ({pair_first_q, tx_data_i})
                            2'h3: line_d = lvl(~pair_mode_q);
                            2'h2: line_d = lvl(~pair_mode_q);
                            2'h1: line_d = PTC_LVL_ZERO;
                            default: line_d = lvl(pair_mode_q);
                        endcase
                        if (pair_first_q ^ tx_data_i) begin
                            pair_mode_d = ~pair_mode_q;
                        end
                    end
                end
                PTC_MODE_DUO_C: begin
                    pre_d = ~tx_data_i ^ pre_q;
                    // sum of successive precoded bits: equal gives outer level
                    if (pre_d == pre_q) begin
                        line_d = lvl(pre_q);
                    end else begin
                        line_d = PTC_LVL_ZERO;
                    end
                end
                default: line_d = PTC_LVL_ZERO;
            endcase
        end else begin
            // second half: return to zero except full-bit, paired and duobinary codes
            if (mode_i != PTC_MODE_DIF_C && mode_i != PTC_MODE_DUO_C &&
                mode_i != PTC_MODE_PAIR_C) begin
                line_d = PTC_LVL_ZERO;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_q <= 1'b0;
            line_q <= PTC_LVL_ZERO;
            pol_q <= PTC_POL_RESET;
            prev_q <= 1'b0;
            pre_q <= 1'b0;
            pair_mode_q <= 1'b0;
            pair_half_q <= 1'b0;
            pair_first_q <= 1'b0;
            run_q <= PTC_RUN_RESET;
            sub_q <= 3'h0;
            take_q <= 1'b0;
            cur_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            line_q <= line_d;
            pol_q <= pol_d;
            prev_q <= prev_d;
            pre_q <= pre_d;
            pair_mode_q <= pair_mode_d;
            pair_half_q <= pair_half_d;
            pair_first_q <= pair_first_d;
            run_q <= run_d;
            sub_q <= sub_d;
            take_q <= take_d;
            cur_q <= cur_d;
        end
    end

    assign tx_take_o = take_q;
    assign line_o = line_q;

    ////////////////////////////////////////////////////////////////////////////
    // receiver: line and bit clock synchronised, decide once per bit
    logic [1:0] ls1_q, ls2_q;
    logic bs1_q, bs2_q, bs3_q;
    logic rx_last_pol_q, rx_last_pol_d;
    logic rx_seen_q, rx_seen_d;
    logic [1:0] rx_lvl_q, rx_lvl_d;
    logic [2:0] rx_zero_q, rx_zero_d;
    logic [1:0] rx_prev_lvl_q, rx_prev_lvl_d;
    logic rx_prev_bit_q, rx_prev_bit_d;
    ptc_rx_type rx_q, rx_d;
    logic rx_phase_q, rx_phase_d;
    logic rx_tick;
    logic [1:0] s_lvl;
    logic s_pulse, s_pol;

    always_comb begin
        s_lvl = ls2_q;
        s_pulse = (s_lvl != PTC_LVL_ZERO);
        s_pol = (s_lvl == PTC_LVL_POS);
        // duobinary uses the supplied bit clock; others follow own phase
        rx_tick = (mode_i == PTC_MODE_DUO_C) ? (bs2_q & ~bs3_q) : ~rx_phase_q;
        rx_phase_d = ~rx_phase_q;
        rx_last_pol_d = rx_last_pol_q;
        rx_seen_d = rx_seen_q;
        rx_lvl_d = rx_lvl_q;
        rx_zero_d = rx_zero_q;
        rx_prev_lvl_d = rx_prev_lvl_q;
        rx_prev_bit_d = rx_prev_bit_q;
        rx_d = '0;
        if (rx_tick) begin
            rx_d.bit_valid = 1'b1;
            case (mode_i)
                PTC_MODE_POLAR_C: rx_d.data = s_pol;
                PTC_MODE_DUO_C: begin
                    rx_d.data = ~s_pulse;
                    rx_d.violation = (s_pulse && rx_prev_lvl_q != PTC_LVL_ZERO &&
                                      s_lvl != rx_prev_lvl_q);
                    rx_prev_lvl_d = s_lvl;
                end
                PTC_MODE_DIF_C, PTC_MODE_DIH_C: begin
                    rx_d.data = s_pulse ? ~rx_prev_bit_q : rx_prev_bit_q;
                    rx_prev_bit_d = rx_d.data;
                    if (s_pulse) begin
                        rx_d.violation = rx_seen_q && (s_pol == rx_last_pol_q);
                        rx_last_pol_d = s_pol;
                        rx_seen_d = 1'b1;
                    end
                end
                default: begin
                    rx_d.data = s_pulse;
                    if (s_pulse) begin
                        if (rx_seen_q && s_pol == rx_last_pol_q) begin
                            if (mode_i == PTC_MODE_TZS_C &&
                                rx_zero_q == 3'(PTC_TZS_ZERO_RUN - 1)) begin
                                rx_d.data = 1'b0;
                            end else begin
                                rx_d.violation = 1'b1;
                            end
                        end
                        rx_last_pol_d = s_pol;
                        rx_seen_d = 1'b1;
                        rx_zero_d = 3'h0;
                    end else if (rx_zero_q != 3'h7) begin
                        rx_zero_d = rx_zero_q + 3'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ls1_q <= PTC_LVL_ZERO;
            ls2_q <= PTC_LVL_ZERO;
            bs1_q <= 1'b0;
            bs2_q <= 1'b0;
            bs3_q <= 1'b0;
            rx_last_pol_q <= 1'b0;
            rx_seen_q <= 1'b0;
            rx_lvl_q <= PTC_LVL_ZERO;
            rx_zero_q <= 3'h0;
            rx_prev_lvl_q <= PTC_LVL_ZERO;
            rx_prev_bit_q <= 1'b0;
            rx_q <= '0;
            rx_phase_q <= 1'b0;
        end else begin
            ls1_q <= line_i;
            ls2_q <= ls1_q;
            bs1_q <= rx_bit_clk_i;
            bs2_q <= bs1_q;
            bs3_q <= bs2_q;
            rx_last_pol_q <= rx_last_pol_d;
            rx_seen_q <= rx_seen_d;
            rx_lvl_q <= rx_lvl_d;
            rx_zero_q <= rx_zero_d;
            rx_prev_lvl_q <= rx_prev_lvl_d;
            rx_prev_bit_q <= rx_prev_bit_d;
            rx_q <= rx_d;
            rx_phase_q <= rx_phase_d;
        end
    end

    assign rx_o = rx_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence one_taken_s;
        phase_q == 1'b0 && tx_data_i && mode_i == PTC_MODE_AMI_C;
    endsequence

    level_legal_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        line_o != 2'h2) else $error("illegal line code");
    polar_pulse_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (phase_q == 1'b0 && mode_i == PTC_MODE_POLAR_C) ##1 mode_i == PTC_MODE_POLAR_C
        |-> line_o == lvl(cur_q) ##1 line_o == PTC_LVL_ZERO)
        else $error("polar pulse wrong");
    ami_alt_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        one_taken_s |=> line_o == lvl($past(pol_q)) && pol_q != $past(pol_q))
        else $error("mark polarity did not alternate");
    ami_zero_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (phase_q == 1'b0 && !tx_data_i && mode_i == PTC_MODE_AMI_C && !six_zero_en_i)
        |=> line_o == PTC_LVL_ZERO) else $error("zero bit not at zero level");
    subst_pulse_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (phase_q == 1'b0 && !tx_data_i && mode_i == PTC_MODE_TZS_C && run_q == 3'h3)
        |=> line_o == lvl(~pol_q)) else $error("substitution pulse wrong");
    dicode_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (phase_q == 1'b0 && mode_i == PTC_MODE_DIF_C && tx_data_i == prev_q)
        |=> line_o == PTC_LVL_ZERO) else $error("pulse without transition");
    duo_jump_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (mode_i == PTC_MODE_DUO_C && $past(mode_i) == PTC_MODE_DUO_C &&
         $past(line_o) != PTC_LVL_ZERO && line_o != PTC_LVL_ZERO)
        |-> line_o == $past(line_o)) else $error("outer level jump");
    pair_mode_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (phase_q == 1'b0 && mode_i == PTC_MODE_PAIR_C && !pair_half_q)
        |=> pair_mode_q == $past(pair_mode_q)) else $error("mode changed mid pair");
    rx_once_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (rx_o.bit_valid && mode_i == PTC_MODE_AMI_C && $past(mode_i) == PTC_MODE_AMI_C)
        |=> !rx_o.bit_valid) else $error("two decisions in one bit");
endmodule

// *** verif/ptc_line_model.sv ***
module ptc_line_model
    import ptc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [1:0] tx_line_i,
    input wire logic [1:0] fault_i,
    output logic [1:0] rx_line_o,
    output logic bit_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ptc_pkg::*;
    logic [1:0] step_q;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            step_q <= 2'h0;
        end else begin
            step_q <= step_q + 2'h1;
        end
    end
    // free-running bit clock for the receiver side
    assign bit_clk_o = step_q[0];
    ////////////////////////////////////////////////////////////////////////////////
    // fault 1: positive pulses that never alternate, fault 2: outer level jumps
    always_comb begin
        case (fault_i)
            2'h1: rx_line_o = step_q[1] ? PTC_LVL_ZERO : PTC_LVL_POS;
            2'h2: rx_line_o = step_q[1] ? PTC_LVL_NEG : PTC_LVL_POS;
            default: rx_line_o = tx_line_i;
        endcase
    end
endmodule

// *** verif/pseudoternary_line_codec_tb.sv ***
module pseudoternary_line_codec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ptc_pkg::*;
    localparam logic [1:0] lz = PTC_LVL_ZERO;
    localparam logic [1:0] lp = PTC_LVL_POS;
    localparam logic [1:0] ln = PTC_LVL_NEG;
    logic core_clk_i;
    logic reset_n_i;
    ptc_mode_type mode_i;
    logic six_zero_en_i;
    logic tx_data_i;
    logic tx_take_o;
    logic [1:0] line_o;
    logic [1:0] line_i;
    logic rx_bit_clk_i;
    ptc_rx_type rx_o;
    logic [1:0] fault;
    int n_mismatch;
    int tests_run;

    ptc_codec ptc_codec_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .mode_i(mode_i), .six_zero_en_i(six_zero_en_i), .tx_data_i(tx_data_i),
        .tx_take_o(tx_take_o), .line_o(line_o), .line_i(line_i),
        .rx_bit_clk_i(rx_bit_clk_i), .rx_o(rx_o));
    ptc_line_model ptc_line_model_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .tx_line_i(line_o), .fault_i(fault), .rx_line_o(line_i), .bit_clk_o(rx_bit_clk_i));

    always #5 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic do_reset(input ptc_mode_type m, input logic sz);
        @(negedge core_clk_i);
        reset_n_i = 1'b0;
        mode_i = m;
        six_zero_en_i = sz;
        tx_data_i = 1'b0;
        fault = 2'h0;
        repeat (8) @(negedge core_clk_i);
        check("line in reset", line_o, lz);
        check("valid in reset", {1'b0, rx_o.bit_valid}, 2'h0);
        check("take in reset", {1'b0, tx_take_o}, 2'h0);
        reset_n_i = 1'b1;
    endtask

    task automatic wait_take();
        int w;
        w = 0;
        while (tx_take_o !== 1'b1 && w < 4) begin
            @(negedge core_clk_i);
            w++;
        end
        check("take strobe", {1'b0, tx_take_o}, 2'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // bits and levels are listed first-sent first, two half-bit levels per bit
    task automatic send(input string what, input ptc_mode_type m, input logic sz,
                        input logic [15:0] bits, input int n, input logic [31:0] exp);
        logic [1:0] seen [$];
        do_reset(m, sz);
        wait_take();
        fork
            for (int i = 0; i < n; i++) begin
                if (i > 0) begin
                    @(negedge core_clk_i);
                    wait_take();
                end
                tx_data_i = bits[n - 1 - i];
            end
            begin
                @(negedge core_clk_i);
                repeat (2 * n) begin
                    @(negedge core_clk_i);
                    seen.push_back(line_o);
                end
            end
        join
        for (int i = 0; i < 2 * n; i++) begin
            check(what, seen[i], exp[4 * n - 1 - 2 * i -: 2]);
        end
        $display("done %s", what);
    endtask

    task automatic watch(input string what, input ptc_mode_type m, input logic d,
                         input logic [1:0] f, input logic exp_viol);
        int nv;
        int nb;
        do_reset(m, 1'b0);
        tx_data_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        tx_data_i = d;
        fault = f;
        nv = 0;
        nb = 0;
        repeat (40) begin
            @(negedge core_clk_i);
            if (rx_o.violation === 1'b1) nv++;
            if (rx_o.bit_valid === 1'b1) nb++;
        end
        check(what, {1'b0, nv != 0}, {1'b0, exp_viol});
        check("bits per interval", {1'b0, nb inside {[19:21]}}, 2'h1);
        $display("done %s", what);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        core_clk_i = 1'b0;
        reset_n_i = 1'b0;
        mode_i = PTC_MODE_POLAR_C;
        six_zero_en_i = 1'b0;
        tx_data_i = 1'b0;
        fault = 2'h0;
        n_mismatch = 0;
        tests_run = 0;
        // a zero bit is always taken at the first edge after reset, ahead of the list
        send("polar rz", PTC_MODE_POLAR_C, 1'b0, 16'h2, 2, {lp, lz, ln, lz});
        send("alternate", PTC_MODE_AMI_C, 1'b0, 16'hb, 4,
             {lp, lz, lz, lz, ln, lz, lp, lz});
        send("three zero", PTC_MODE_TZS_C, 1'b0, 16'h10, 5,
             {lp, lz, lz, lz, lz, lz, lz, lz, lp, lz});
        send("six zero", PTC_MODE_AMI_C, 1'b1, 16'h40, 7,
             {lp, lz, lz, lz, lz, lz, lz, lz, lz, lz, lz, lz, lp, lz});
        send("transition full", PTC_MODE_DIF_C, 1'b0, 16'h6, 4,
             {lz, lz, lp, lp, lz, lz, ln, ln});
        send("transition half", PTC_MODE_DIH_C, 1'b0, 16'h6, 4,
             {lz, lz, lp, lz, lz, lz, ln, lz});
        send("duobinary", PTC_MODE_DUO_C, 1'b0, 16'h69, 7,
             {lp, lp, lp, lp, lz, lz, ln, ln, lz, lz, lz, lz, ln, ln});
        send("paired", PTC_MODE_PAIR_C, 1'b0, 16'ha, 5,
             {ln, ln, lz, lz, lp, lp, lz, lz, ln, ln});
        watch("alternate clean", PTC_MODE_AMI_C, 1'b1, 2'h0, 1'b0);
        watch("alternate fault", PTC_MODE_AMI_C, 1'b1, 2'h1, 1'b1);
        watch("three zero clean", PTC_MODE_TZS_C, 1'b0, 2'h0, 1'b0);
        watch("transition fault", PTC_MODE_DIF_C, 1'b1, 2'h1, 1'b1);
        watch("duobinary clean", PTC_MODE_DUO_C, 1'b1, 2'h0, 1'b0);
        watch("duobinary fault", PTC_MODE_DUO_C, 1'b1, 2'h2, 1'b1);
        give_verdict();
    end
endmodule
